// [vtsr_pkg.sv]
// vtsr_pkg: constants for the regulator telemetry and status register bank.
// Assumes: 8-bit registers reached by a register index over the serial bus.
package vtsr_pkg;

  // bus field widths
  localparam int DOMAIN_BITS = 4;
  localparam int INDEX_BITS = 8;
  localparam int DATA_BITS = 8;

  // bus domain addresses of the two register views
  localparam logic [DOMAIN_BITS-1:0] DOMAIN_MAIN = 4'h0;
  localparam logic [DOMAIN_BITS-1:0] DOMAIN_INPUT_POWER = 4'hd;

  // register indices
  localparam logic [INDEX_BITS-1:0] IDX_CAPABILITY = 8'h06;
  localparam logic [INDEX_BITS-1:0] IDX_PRIMARY_STATUS = 8'h10;
  localparam logic [INDEX_BITS-1:0] IDX_SECONDARY_STATUS = 8'h11;
  localparam logic [INDEX_BITS-1:0] IDX_TEMPERATURE_ZONE = 8'h12;
  localparam logic [INDEX_BITS-1:0] IDX_OUTPUT_CURRENT = 8'h15;
  localparam logic [INDEX_BITS-1:0] IDX_OUTPUT_VOLTAGE = 8'h16;
  localparam logic [INDEX_BITS-1:0] IDX_REG_TEMPERATURE = 8'h17;
  localparam logic [INDEX_BITS-1:0] IDX_OUTPUT_POWER = 8'h18;
  localparam logic [INDEX_BITS-1:0] IDX_INPUT_VOLTAGE = 8'h1a;
  localparam logic [INDEX_BITS-1:0] IDX_INPUT_POWER = 8'h1b;
  localparam logic [INDEX_BITS-1:0] IDX_SEC_STATUS_LAST = 8'h1c;
  localparam logic [INDEX_BITS-1:0] IDX_PLATFORM_LIMIT = 8'h21;
  localparam logic [INDEX_BITS-1:0] IDX_TEMP_LIMIT = 8'h22;

  // reset values
  localparam logic [DATA_BITS-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_BITS-1:0] RST_READING = 8'h01;
  localparam logic [DATA_BITS-1:0] RST_TEMP_LIMIT = 8'h6a;
  localparam logic [DATA_BITS-1:0] RD_UNMAPPED = 8'h00;

  // capability bit positions
  localparam int CAP_IOUT_FORMAT = 7;
  localparam int CAP_TEMP = 6;
  localparam int CAP_VIN = 4;
  localparam int CAP_POUT = 2;
  localparam int CAP_VOUT = 1;
  localparam int CAP_IOUT = 0;
  localparam logic [DATA_BITS-1:0] CAP_VALUE = (8'h01 << CAP_IOUT_FORMAT) |
    (8'h01 << CAP_TEMP) | (8'h01 << CAP_VIN) | (8'h01 << CAP_POUT) |
    (8'h01 << CAP_VOUT) | (8'h01 << CAP_IOUT);

  // output power keeps the top byte of the voltage by current product
  localparam int POUT_MSB = 15;
  localparam int POUT_LSB = 8;

  // current-limit pin capture: wait for the synchroniser, then take once
  localparam logic [1:0] LIMIT_SETTLE = 2'h2;
  localparam logic [1:0] LIMIT_DONE = 2'h3;

  // serial frame bit counts
  localparam logic [3:0] LAST_DOMAIN_BIT = 4'h3;
  localparam logic [3:0] LAST_BYTE_BIT = 4'h7;

  typedef enum logic [2:0] {
    LS_IDLE, LS_DOMAIN, LS_DIR, LS_INDEX, LS_WDATA, LS_TURN, LS_RDATA
  } vtsr_link_state_type;

endpackage : vtsr_pkg

// [vtsr_link_engine.sv]
// vtsr_link_engine: serial frame engine on the master's bus clock.
// Assumes: bus clock runs inside frames and while reset is held; the register side answers a
// request toggle with an ack toggle and holds read data until the next one.
`timescale 1ns/100ps
module vtsr_link_engine #(
  parameter int TURN_CYCLES = 6
) (
  // bus clock and reset from the register side
  input wire logic link_clk,
  input wire logic rst_n,
  // serial data pin
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  // request toward the register side
  output logic req_toggle,
  output logic req_pwr,
  output logic req_write,
  output logic [vtsr_pkg::INDEX_BITS-1:0] req_index,
  output logic [vtsr_pkg::DATA_BITS-1:0] req_wdata,
  // answer from the register side
  input wire logic ack_toggle,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] rd_data
);
  import vtsr_pkg::*;

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic ack1;
    logic ack2;
    vtsr_link_state_type st;
    logic [3:0] cnt;
    logic [DOMAIN_BITS-1:0] dom;
    logic match;
    logic [DATA_BITS-1:0] shift;
    logic [DATA_BITS-1:0] rbuf;
    logic tgl;
    logic pwr;
    logic wr;
    logic [INDEX_BITS-1:0] idx;
    logic [DATA_BITS-1:0] wdata;
    logic dout;
    logic doe;
  } vtsr_link_reg_type;

  vtsr_link_reg_type s_reg;
  vtsr_link_reg_type s_next;

  // frame decode; bits are sampled on rising edges, msb first
  always_comb begin
    s_next = s_reg;
    s_next.rs1 = rst_n;
    s_next.rs2 = s_reg.rs1;
    s_next.ack1 = ack_toggle;
    s_next.ack2 = s_reg.ack1;
    s_next.cnt = s_reg.cnt + 4'h1;
    s_next.shift = {s_reg.shift[DATA_BITS-2:0], sdata_in};
    unique case (s_reg.st)
      LS_IDLE: begin
        s_next.cnt = 4'h0;
        if (!sdata_in) begin
          s_next.st = LS_DOMAIN;
        end
      end
      LS_DOMAIN: begin
        s_next.dom = {s_reg.dom[DOMAIN_BITS-2:0], sdata_in};
        if (s_reg.cnt == LAST_DOMAIN_BIT) begin
          s_next.st = LS_DIR;
        end
      end
      LS_DIR: begin
        // frames for other domains are tracked but never answered
        s_next.match = (s_reg.dom == DOMAIN_MAIN) || (s_reg.dom == DOMAIN_INPUT_POWER);
        s_next.pwr = (s_reg.dom == DOMAIN_INPUT_POWER);
        s_next.wr = sdata_in;
        s_next.cnt = 4'h0;
        s_next.st = LS_INDEX;
      end
      LS_INDEX: begin
        if (s_reg.cnt == LAST_BYTE_BIT) begin
          s_next.idx = {s_reg.shift[DATA_BITS-2:0], sdata_in};
          s_next.cnt = 4'h0;
          s_next.st = s_reg.wr ? LS_WDATA : LS_TURN;
          if (!s_reg.wr && s_reg.match) begin
            s_next.tgl = ~s_reg.tgl;
          end
        end
      end
      LS_WDATA: begin
        if (s_reg.cnt == LAST_BYTE_BIT) begin
          s_next.wdata = {s_reg.shift[DATA_BITS-2:0], sdata_in};
          s_next.st = LS_IDLE;
          if (s_reg.match) begin
            s_next.tgl = ~s_reg.tgl;
          end
        end
      end
      LS_TURN: begin
        // a late answer leaves the line released, so it reads all ones
        if (s_reg.cnt == 4'(TURN_CYCLES - 1)) begin
          s_next.cnt = 4'h0;
          s_next.st = LS_RDATA;
          s_next.rbuf = rd_data;
          s_next.dout = rd_data[DATA_BITS-1];
          s_next.doe = s_reg.match && (s_reg.ack2 == s_reg.tgl);
        end
      end
      LS_RDATA: begin
        s_next.rbuf = {s_reg.rbuf[DATA_BITS-2:0], 1'b0};
        s_next.dout = s_reg.rbuf[DATA_BITS-2];
        if (s_reg.cnt == LAST_BYTE_BIT) begin
          s_next.doe = 1'b0;
          s_next.st = LS_IDLE;
        end
      end
    endcase
    // held clear until the release has passed both synchroniser stages
    if (!s_reg.rs2) begin
      s_next = '0;
      s_next.rs1 = rst_n;
      s_next.rs2 = s_reg.rs1;
      s_next.ack2 = s_reg.ack1;
      s_next.ack1 = ack_toggle;
      s_next.st = LS_IDLE;
    end
  end

  always_ff @(posedge link_clk) begin
    s_reg <= s_next;
  end

  assign sdata_out = s_reg.dout;
  assign sdata_oe = s_reg.doe;
  assign req_toggle = s_reg.tgl;
  assign req_pwr = s_reg.pwr;
  assign req_write = s_reg.wr;
  assign req_index = s_reg.idx;
  assign req_wdata = s_reg.wdata;

endmodule : vtsr_link_engine

// [vtsr_register_bank.sv]
// vtsr_register_bank: telemetry and status registers of a voltage regulator,
// read and partly written by the processor over the serial control bus.
// Assumes: converter results and status inputs are on clk; the bus clock
// comes from the master; the current-limit pin is asynchronous to clk.
//
// Summary of operation
// - capability low three bits read one
// - primary status follows its source, read clears attention
// - secondary status read copies into last-read
// - temperature zone presented read-only
// - output current code, full scale is limit
// - output voltage is sense difference, 8 mV
// - temperature in degrees, zero means unsupported
// - output power is voltage times current byte
// - input voltage code, (code-2)/7 volts
// - input power in power domain, reset zero
// - current limit pin sampled once after reset
// - writable temperature limit drives over-temp flag
// - attention is open-drain, requests status read
// - capability bit 7 set: current full-scale format
// - master clocks bus, data line bidirectional
`timescale 1ns/100ps
module vtsr_register_bank #(
  parameter int TURN_CYCLES = 6
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // serial bus pins
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  output logic attn_out,
  output logic attn_oe,
  // status sources
  input wire logic [vtsr_pkg::DATA_BITS-1:0] primary_status_in,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] secondary_status_in,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] temperature_zone_in,
  // converter results
  input wire logic [vtsr_pkg::DATA_BITS-1:0] current_code,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] sense_positive,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] sense_negative,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] temperature_code,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] input_voltage_code,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] input_power_code,
  // platform pins
  input wire logic [vtsr_pkg::DATA_BITS-1:0] max_current_config_pin,
  output logic overtemp_flag_n
);
  import vtsr_pkg::*;

  typedef struct packed {
    logic rq1;
    logic rq2;
    logic rq3;
    logic ack;
    logic [DATA_BITS-1:0] rdata;
    logic [DATA_BITS-1:0] pin1;
    logic [DATA_BITS-1:0] pin2;
    logic [1:0] cap_cnt;
    logic [DATA_BITS-1:0] plat_limit;
    logic [DATA_BITS-1:0] stat1;
    logic [DATA_BITS-1:0] stat2;
    logic [DATA_BITS-1:0] zone;
    logic [DATA_BITS-1:0] iout;
    logic [DATA_BITS-1:0] vout;
    logic [DATA_BITS-1:0] temp;
    logic [DATA_BITS-1:0] pout;
    logic [DATA_BITS-1:0] vin;
    logic [DATA_BITS-1:0] inpwr;
    logic [DATA_BITS-1:0] s2_last;
    logic [DATA_BITS-1:0] temp_limit;
    logic attn;
    logic attn_level;
    logic hot_n;
  } vtsr_core_type;

  vtsr_core_type s_reg;
  vtsr_core_type s_next;

  // request words from the bus side; stable once the toggle is seen
  logic req_toggle;
  logic req_pwr;
  logic req_write;
  logic [INDEX_BITS-1:0] req_index;
  logic [DATA_BITS-1:0] req_wdata;
  logic req_seen;
  logic attn_set;
  logic attn_clr;

  // top byte of the product; the low byte is below one power step
  function automatic logic [DATA_BITS-1:0] power_byte(
    input logic [DATA_BITS-1:0] volts,
    input logic [DATA_BITS-1:0] amps
  );
    logic [2*DATA_BITS-1:0] prod;
    prod = volts * amps;
    return prod[POUT_MSB:POUT_LSB];
  endfunction : power_byte

  // read decode for both bus domains
  function automatic logic [DATA_BITS-1:0] read_value(
    input logic pwr,
    input logic [INDEX_BITS-1:0] idx,
    input vtsr_core_type c
  );
    logic [DATA_BITS-1:0] v;
    v = RD_UNMAPPED;
    if (pwr) begin
      // the input power view holds only status and input power
      case (idx)
        IDX_PRIMARY_STATUS: v = c.stat1;
        IDX_SECONDARY_STATUS: v = c.stat2;
        IDX_INPUT_POWER: v = c.inpwr;
        default: v = RD_UNMAPPED;
      endcase
    end else begin
      case (idx)
        IDX_CAPABILITY: v = CAP_VALUE;
        IDX_PRIMARY_STATUS: v = c.stat1;
        IDX_SECONDARY_STATUS: v = c.stat2;
        IDX_TEMPERATURE_ZONE: v = c.zone;
        IDX_OUTPUT_CURRENT: v = c.iout;
        IDX_OUTPUT_VOLTAGE: v = c.vout;
        IDX_REG_TEMPERATURE: v = c.temp;
        IDX_OUTPUT_POWER: v = c.pout;
        IDX_INPUT_VOLTAGE: v = c.vin;
        IDX_SEC_STATUS_LAST: v = c.s2_last;
        IDX_PLATFORM_LIMIT: v = c.plat_limit;
        IDX_TEMP_LIMIT: v = c.temp_limit;
        default: v = RD_UNMAPPED;
      endcase
    end
    return v;
  endfunction : read_value

  // bus-clock side: frame decode and pin drive
  vtsr_link_engine #(
    .TURN_CYCLES(TURN_CYCLES)
  ) u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .sdata_in(sdata_in),
    .sdata_out(sdata_out),
    .sdata_oe(sdata_oe),
    .req_toggle(req_toggle),
    .req_pwr(req_pwr),
    .req_write(req_write),
    .req_index(req_index),
    .req_wdata(req_wdata),
    .ack_toggle(s_reg.ack),
    .rd_data(s_reg.rdata)
  );

  // a request toggle that has passed both synchroniser stages
  assign req_seen = s_reg.rq3 != s_reg.rq2;

  // attention rises on a new non-zero status; a read of it clears
  assign attn_set = (primary_status_in != s_reg.stat1) &&
    (primary_status_in != RST_ZERO);
  assign attn_clr = req_seen && !req_write && (req_index == IDX_PRIMARY_STATUS);

  // next state of the whole bank
  always_comb begin
    s_next = s_reg;
    // request toggle crossing: two stages, third only for edge detect
    s_next.rq1 = req_toggle;
    s_next.rq2 = s_reg.rq1;
    s_next.rq3 = s_reg.rq2;
    // current-limit pin passes two stages before capture
    s_next.pin1 = max_current_config_pin;
    s_next.pin2 = s_reg.pin1;
    if (s_reg.cap_cnt != LIMIT_DONE) begin
      s_next.cap_cnt = s_reg.cap_cnt + 2'h1;
    end
    if (s_reg.cap_cnt == LIMIT_SETTLE) begin
      s_next.plat_limit = s_reg.pin2;
    end
    // status and zone follow their sources every cycle
    s_next.stat1 = primary_status_in;
    s_next.stat2 = secondary_status_in;
    s_next.zone = temperature_zone_in;
    // the converter already scales its full-scale code to the limit
    s_next.iout = current_code;
    // a negative sense difference reads as zero, not as a wrapped code
    if (sense_positive > sense_negative) begin
      s_next.vout = sense_positive - sense_negative;
    end else begin
      s_next.vout = RST_ZERO;
    end
    s_next.temp = temperature_code;
    s_next.pout = power_byte(s_reg.vout, s_reg.iout);
    s_next.vin = input_voltage_code;
    s_next.inpwr = input_power_code;
    // one bus access per request toggle
    if (req_seen) begin
      s_next.ack = ~s_reg.ack;
      if (req_write) begin
        // only the temperature limit takes writes; the rest stay put
        if (!req_pwr && (req_index == IDX_TEMP_LIMIT)) begin
          s_next.temp_limit = req_wdata;
        end
      end else begin
        s_next.rdata = read_value(req_pwr, req_index, s_reg);
        if (req_index == IDX_SECONDARY_STATUS) begin
          s_next.s2_last = s_reg.stat2;
        end
      end
    end
    // a new status in the same cycle as the read keeps the line low
    s_next.attn = attn_set || (s_reg.attn && !attn_clr);
    s_next.attn_level = 1'b0;
    // zero temperature means no sensor, so never flag it hot
    s_next.hot_n = !((s_reg.temp != RST_ZERO) &&
      (s_reg.temp >= s_reg.temp_limit));
    if (!rst_n) begin
      s_next = '0;
      s_next.iout = RST_READING;
      s_next.vout = RST_READING;
      s_next.pout = RST_READING;
      s_next.temp_limit = RST_TEMP_LIMIT;
      s_next.hot_n = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  // open-drain attention: drives low only while enabled
  assign attn_out = s_reg.attn_level;
  assign attn_oe = s_reg.attn;
  assign overtemp_flag_n = s_reg.hot_n;

endmodule : vtsr_register_bank

// [vtsr_register_bank_properties.sv]
// vtsr_checker: port-level properties of the register bank.
// Assumes: bound to vtsr_register_bank; link clock runs during reset.
`timescale 1ns/100ps
module vtsr_checker (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // watched pins
  input wire logic sdata_oe,
  input wire logic attn_out,
  input wire logic attn_oe,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] primary_status_in,
  input wire logic [vtsr_pkg::DATA_BITS-1:0] temperature_code,
  input wire logic overtemp_flag_n
);
  import vtsr_pkg::*;
  // core side: attention and over-temperature flag
  a_attn_drive_low: assert property (@(posedge clk) disable iff (!rst_n) !attn_out)
    else $error("attention driven high");
  a_attn_on_change: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $changed(primary_status_in) && primary_status_in != 8'h00 |=> attn_oe)
    else $error("attention not raised");
  a_reset_quiet: assert property (@(posedge clk) !rst_n |=> !attn_oe && overtemp_flag_n)
    else $error("outputs active in reset");
  // zero means no sensor, so it never flags; full scale is at or above any limit
  a_temp_zero_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (temperature_code == 8'h00) [*5] |-> overtemp_flag_n) else $error("flag on zero");
  a_temp_full_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (temperature_code == 8'hff) [*5] |-> !overtemp_flag_n) else $error("no flag at ff");
  // link side: data pin released in reset, answer is exactly one byte long
  a_link_reset: assert property (@(posedge link_clk) !rst_n [*3] |=> !sdata_oe)
    else $error("data driven in reset");
  a_answer_len: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(sdata_oe) |-> sdata_oe [*8] ##1 !sdata_oe) else $error("answer length");
  a_answer_gap: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(sdata_oe) |-> !sdata_oe [*8]) else $error("answer too soon");
  // main scenarios
  cover property (@(posedge link_clk) $rose(sdata_oe));
  cover property (@(posedge clk) $rose(attn_oe));
  cover property (@(posedge clk) $fell(overtemp_flag_n));
endmodule : vtsr_checker
bind vtsr_register_bank vtsr_checker u_checker (.clk, .rst_n, .link_clk, .sdata_oe,
  .attn_out, .attn_oe, .primary_status_in, .temperature_code, .overtemp_flag_n);

// [vtsr_bus_master_model.sv]
// vtsr_bus_master_model: processor side of the serial control bus.
// Assumes: device samples data on the rising bus clock; lines pulled up.
`timescale 1ns/100ps
module vtsr_bus_master_model #(
  parameter int TURN_CYCLES = 6
) (
  // bus clock and resolved lines
  output logic link_clk,
  output logic sdata_line,
  output logic attn_line_n,
  // device pin halves
  input wire logic sdata_out,
  input wire logic sdata_oe,
  input wire logic attn_out,
  input wire logic attn_oe
);
  import vtsr_pkg::*;
  logic drive_val;
  // a released attention line floats to the pull-up level; a released data line carries drive_val
  assign sdata_line = sdata_oe ? sdata_out : drive_val;
  assign attn_line_n = attn_oe ? attn_out : 1'b1;
  // clock stands still between frames
  initial begin
    link_clk = 1'b0;
    drive_val = 1'b1;
  end
  // one bus clock: data moves on the falling edge, device takes it rising
  task automatic tick(input logic b);
    link_clk = 1'b0;
    drive_val = b;
    #7.5;
    link_clk = 1'b1;
    #7.5;
  endtask : tick
  // start bit, domain, direction and index, msb first
  task automatic head(input logic [3:0] dom, input logic wr, input logic [7:0] idx);
    logic [13:0] f;
    f = {1'b0, dom, wr, idx};
    for (int i = 13; i >= 0; i--) tick(f[i]);
  endtask : head
  // the master may rewrite the temperature limit
  task automatic write(input logic [3:0] dom, input logic [7:0] idx, input logic [7:0] d);
    head(dom, 1'b1, idx);
    for (int i = 7; i >= 0; i--) tick(d[i]);
    drive_val = 1'b1;
  endtask : write
  // turnaround, then eight answer bits; the last edge releases the line
  task automatic read(input logic [3:0] dom, input logic [7:0] idx, output logic [7:0] d);
    head(dom, 1'b0, idx);
    repeat (TURN_CYCLES) tick(1'b1);
    for (int i = 7; i >= 0; i--) begin
      link_clk = 1'b0;
      #7.5;
      d[i] = sdata_line;
      link_clk = 1'b1;
      #7.5;
    end
  endtask : read
  task automatic idle(input int n);
    repeat (n) tick(1'b1);
  endtask : idle
endmodule : vtsr_bus_master_model

// [vtsr_register_bank_tb.sv]
// vtsr_register_bank_tb: register reads and writes over the serial bus.
// Assumes: the master model makes the bus clock; core clock 250 MHz.
`timescale 1ns/100ps
module vtsr_register_bank_tb;
  import vtsr_pkg::*;
  logic clk, rst_n, link_clk, sdata_in, sdata_out, sdata_oe;
  logic attn_out, attn_oe, attn_line_n, overtemp_flag_n;
  logic [7:0] primary_status_in, secondary_status_in, temperature_zone_in;
  logic [7:0] current_code, sense_positive, sense_negative, temperature_code;
  logic [7:0] input_voltage_code, input_power_code, max_current_config_pin;
  int mismatches, checked;
  // core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  vtsr_register_bank #(.TURN_CYCLES(6)) DUT (.clk, .rst_n, .link_clk, .sdata_in,
    .sdata_out, .sdata_oe, .attn_out, .attn_oe, .primary_status_in,
    .secondary_status_in, .temperature_zone_in, .current_code, .sense_positive,
    .sense_negative, .temperature_code, .input_voltage_code, .input_power_code,
    .max_current_config_pin, .overtemp_flag_n);
  vtsr_bus_master_model #(.TURN_CYCLES(6)) master (.link_clk, .sdata_line(sdata_in),
    .attn_line_n, .sdata_out, .sdata_oe, .attn_out, .attn_oe);
  // comparisons and verdict
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // bus access; main domain unless stated
  task automatic rd(input logic [3:0] dom, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    master.read(dom, idx, v);
    check8(v, exp);
  endtask : rd
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk
  // bounded wait on the attention line
  task automatic wait_attn(input logic lvl);
    int n;
    n = 0;
    while (attn_line_n !== lvl && n < 20) begin
      @(posedge clk);
      n++;
    end
    check1(attn_line_n, lvl);
    // only a wait that ran out without the level ends the run early
    if (attn_line_n !== lvl)
      stop_test();
  endtask : wait_attn
  // link clock must run while reset is held, and after release
  task automatic do_reset();
    rst_n <= 1'b0;
    fork
      wait_clk(5);
      master.idle(3);
    join
    @(posedge clk);
    rst_n <= 1'b1;
    master.idle(3);
  endtask : do_reset
  initial begin
    rst_n = 1'b0;
    mismatches = 0;
    checked = 0;
    primary_status_in = 8'h00;
    secondary_status_in = 8'h00;
    temperature_zone_in = 8'h03;
    current_code = 8'hc0;
    sense_positive = 8'h90;
    sense_negative = 8'h10;
    temperature_code = 8'h2d;
    input_voltage_code = 8'h56;
    input_power_code = 8'h7b;
    max_current_config_pin = 8'h5a;
    @(posedge clk);
    do_reset();
    // reset values, capability and live readings
    rd(4'h0, 8'h22, 8'h6a);
    rd(4'h0, 8'h06, 8'hd7);
    rd(4'h0, 8'h10, 8'h00);
    rd(4'h0, 8'h12, 8'h03);
    rd(4'h0, 8'h15, 8'hc0);
    rd(4'h0, 8'h16, 8'h80);
    rd(4'h0, 8'h17, 8'h2d);
    rd(4'h0, 8'h18, 8'h60);
    rd(4'h0, 8'h1a, 8'h56);
    rd(4'hd, 8'h1b, 8'h7b);
    rd(4'hd, 8'h15, 8'h00);
    rd(4'h0, 8'h40, 8'h00);
    rd(4'h3, 8'h06, 8'hff);
    rd(4'h0, 8'h21, 8'h5a);
    // negative sense difference saturates; read-only places ignore writes
    @(posedge clk);
    sense_positive <= 8'h05;
    sense_negative <= 8'h09;
    max_current_config_pin <= 8'ha5;
    rd(4'h0, 8'h16, 8'h00);
    rd(4'h0, 8'h18, 8'h00);
    master.write(4'h0, 8'h21, 8'hff);
    master.write(4'h0, 8'h15, 8'h00);
    rd(4'h0, 8'h21, 8'h5a);
    rd(4'h0, 8'h15, 8'hc0);
    // last-read copy follows reads only
    @(posedge clk);
    secondary_status_in <= 8'h3c;
    rd(4'h0, 8'h1c, 8'h00);
    rd(4'h0, 8'h11, 8'h3c);
    @(posedge clk);
    secondary_status_in <= 8'h81;
    rd(4'h0, 8'h1c, 8'h3c);
    // attention raised by new status, dropped by the status read
    check1(attn_line_n, 1'b1);
    @(posedge clk);
    primary_status_in <= 8'h05;
    wait_attn(1'b0);
    rd(4'h0, 8'h10, 8'h05);
    wait_attn(1'b1);
    // temperature limit at its boundary, zero reading, ignored domain write
    master.write(4'h0, 8'h22, 8'h40);
    rd(4'h0, 8'h22, 8'h40);
    @(posedge clk);
    temperature_code <= 8'h40;
    wait_clk(4);
    check1(overtemp_flag_n, 1'b0);
    temperature_code <= 8'h3f;
    wait_clk(4);
    check1(overtemp_flag_n, 1'b1);
    master.write(4'h0, 8'h22, 8'h00);
    master.write(4'hd, 8'h22, 8'h11);
    rd(4'h0, 8'h22, 8'h00);
    @(posedge clk);
    temperature_code <= 8'h00;
    wait_clk(6);
    check1(overtemp_flag_n, 1'b1);
    temperature_code <= 8'hff;
    wait_clk(6);
    check1(overtemp_flag_n, 1'b0);
    // second reset restores the limit and samples the pin again
    do_reset();
    rd(4'h0, 8'h22, 8'h6a);
    rd(4'h0, 8'h21, 8'ha5);
    stop_test();
  end
endmodule : vtsr_register_bank_tb
